// ---- include/lbm_map.svh ----
// Purpose: Constants for the long branch, move and OR-immediate execution block
// Assumes: One T-state per clk_i cycle
// Notes: Operation list below; opcodes not fixed by the long-jump formats are local choices
//
// Operation
// - Long call pushes context, loads target, four cycles
// - Conditional long jump tests selected register bit
// - Jump target is full sixteen bits
// - Long jump absolute or indexed, flags untouched
// - Index select 00 W, 01 X, 10 Y, 11 Z
// - Indexed jump word 11001101, zeros, select
// - Memory to register move, any index mode
// - Index plus unsigned accumulator address
// - Z pointer plus unsigned immediate address
// - Z plus immediate load uses registers 0-15
// - Register move to register or memory
// - Z plus immediate store uses registers 0-15
// - Move into transceiver register pushes transmitter FIFO
// - OR immediate, write back, only N and Z
// - OR immediate limited to registers 0-15
`ifndef LBM_MAP_SVH
`define LBM_MAP_SVH

// ==================================================
// Opcodes
`define LBM_OP_LONG_CALL 8'hce
`define LBM_OP_LONG_JUMP 8'hcf
`define LBM_OP_LONG_JUMP_IDX 8'hcd
`define LBM_OP_CJMP 7'h6a
`define LBM_OP_OR 4'h5
`define LBM_OP_MOVE_RR 6'h20
`define LBM_OP_MOVE_MI 6'h21
`define LBM_OP_MOVE_MA 6'h22
`define LBM_OP_MOVE_ZN 3'h7

// ==================================================
// Fields, addresses, reset values
`define LBM_IDX_W 2'h0
`define LBM_IDX_Z 2'h3
`define LBM_TX_DATA_ADDR 5'h1c
`define LBM_PC_RESET 16'h0000
`define LBM_PC_STEP 16'h0001
`define LBM_IDX_STEP 16'h0001

`endif

// ---- include/lbm_pkg.sv ----
// Purpose: Types shared by the execution block files
// Assumes: Nothing beyond SystemVerilog-2012
// Notes: State codes are one-hot
package lbm_pkg;

   typedef enum logic [4:0] {
      LBM_IDLE = 5'h01,
      LBM_FETCH2 = 5'h02,
      LBM_PUSH = 5'h04,
      LBM_LOAD = 5'h08,
      LBM_MEM = 5'h10
   } lbm_state_e;

   typedef enum logic [1:0] {
      LBM_AM_PLAIN = 2'h0,
      LBM_AM_PREINC = 2'h1,
      LBM_AM_POSTDEC = 2'h2,
      LBM_AM_POSTINC = 2'h3
   } lbm_amode_e;

endpackage

// ---- rtl/lbm_addr_gen.sv ----
// Purpose: Data memory address and index update for the index modes
// Assumes: Offset is zero for the pre-increment and post-modify modes
// Notes: Purely combinational
`timescale 1ns/1ps
`include "lbm_map.svh"
module lbm_addr_gen (
   // Index and offset
   input wire lbm_pkg::lbm_amode_e mode_i,
   input wire logic [15:0] idx_i,
   input wire logic [7:0] offset_i,
   // Results
   output logic [15:0] addr_o,
   output logic [15:0] next_idx_o,
   output logic idx_upd_o
);
   import lbm_pkg::*;

   always_comb begin
      addr_o = idx_i + {8'h00, offset_i};
      next_idx_o = idx_i;
      idx_upd_o = 1'b0;
      case (mode_i)
         LBM_AM_PREINC: begin
            addr_o = idx_i + `LBM_IDX_STEP;
            next_idx_o = idx_i + `LBM_IDX_STEP;
            idx_upd_o = 1'b1;
         end
         LBM_AM_POSTDEC: begin
            next_idx_o = idx_i - `LBM_IDX_STEP;
            idx_upd_o = 1'b1;
         end
         LBM_AM_POSTINC: begin
            next_idx_o = idx_i + `LBM_IDX_STEP;
            idx_upd_o = 1'b1;
         end
         default: begin
            idx_upd_o = 1'b0;
         end
      endcase
   end

endmodule

// ---- rtl/lbm_exec.sv ----
// Purpose: Executes long call, long jumps, data moves and OR immediate
// Assumes: Register file, index pointers and program memory answer combinationally on clk_i
// Notes: The block owns the program counter; one instruction word is taken per cycle in idle
`timescale 1ns/1ps
`include "lbm_map.svh"
module lbm_exec #(
   parameter int REG_AW = 5
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Instruction fetch
   input wire logic [15:0] instr_i,
   input wire logic instr_valid_i,
   output logic instr_ready_o,
   output logic [15:0] pc_o,
   // Register file
   output logic [REG_AW-1:0] reg_raddr_o,
   input wire logic [7:0] reg_rdata_i,
   input wire logic [7:0] acc_i,
   output logic reg_we_o,
   output logic [REG_AW-1:0] reg_waddr_o,
   output logic [7:0] reg_wdata_o,
   // Index pointers
   output logic [1:0] idx_sel_o,
   input wire logic [15:0] idx_i,
   output logic idx_we_o,
   output logic [1:0] idx_wsel_o,
   output logic [15:0] idx_wdata_o,
   // Data memory
   output logic [15:0] dm_addr_o,
   output logic dm_rd_o,
   output logic dm_wr_o,
   output logic [7:0] dm_wdata_o,
   input wire logic [7:0] dm_rdata_i,
   input wire logic dm_ack_i,
   // Context and address stack
   input wire logic [3:0] flags_i,
   input wire logic global_irq_enable_i,
   input wire logic [3:0] bank_i,
   output logic stk_push_o,
   output logic [24:0] stk_data_o,
   // Flag update, bit order N Z
   output logic flags_we_o,
   output logic flags_n_o,
   output logic flags_z_o,
   // Transmitter FIFO
   output logic tx_push_o,
   output logic [7:0] tx_data_o
);
   import lbm_pkg::*;

   // ==================================================
   // Elaboration check
   if (REG_AW != 5) begin : g_bad_aw
      $error("lbm_exec: REG_AW must be 5");
   end

   // ==================================================
   // State
   lbm_state_e state, next_state;
   logic [15:0] pc, next_pc;
   logic [15:0] target, next_target;
   logic is_call, next_is_call;
   logic take, next_take;
   logic [4:0] dst, next_dst;
   logic reg_we, next_reg_we;
   logic [4:0] reg_waddr, next_reg_waddr;
   logic [7:0] reg_wdata, next_reg_wdata;
   logic idx_we, next_idx_we;
   logic [1:0] idx_wsel, next_idx_wsel;
   logic [15:0] idx_wdata, next_idx_wdata;
   logic [15:0] dm_addr, next_dm_addr;
   logic dm_rd, next_dm_rd;
   logic dm_wr, next_dm_wr;
   logic [7:0] dm_wdata, next_dm_wdata;
   logic stk_push, next_stk_push;
   logic [24:0] stk_data, next_stk_data;
   logic flags_we, next_flags_we;
   logic flags_n, next_flags_n;
   logic flags_z, next_flags_z;
   logic tx_push, next_tx_push;
   logic [7:0] tx_data, next_tx_data;

   // ==================================================
   // Decode
   logic op_long_call_op, op_long_jump_op, op_long_jump_op_idx, op_cjmp, op_or, op_rr, op_mi, op_ma, op_zn;
   lbm_amode_e amode;
   logic [7:0] offset;
   logic [15:0] ag_addr, ag_next_idx;
   logic ag_upd;
   logic [7:0] or_res;

   assign op_long_call_op = (instr_i[15:8] == `LBM_OP_LONG_CALL);
   assign op_long_jump_op = (instr_i[15:8] == `LBM_OP_LONG_JUMP);
   assign op_long_jump_op_idx = (instr_i[15:8] == `LBM_OP_LONG_JUMP_IDX) && (instr_i[7:2] == 6'h00);
   assign op_cjmp = (instr_i[15:9] == `LBM_OP_CJMP);
   assign op_or = (instr_i[15:12] == `LBM_OP_OR);
   assign op_rr = (instr_i[15:10] == `LBM_OP_MOVE_RR);
   assign op_mi = (instr_i[15:10] == `LBM_OP_MOVE_MI);
   assign op_ma = (instr_i[15:10] == `LBM_OP_MOVE_MA);
   assign op_zn = (instr_i[15:13] == `LBM_OP_MOVE_ZN);
   assign or_res = reg_rdata_i | instr_i[11:4];

   always_comb begin
      reg_raddr_o = instr_i[4:0];
      if (op_rr) begin
         reg_raddr_o = instr_i[9:5];
      end else if (op_or || op_zn) begin
         reg_raddr_o = {1'b0, instr_i[3:0]};
      end
   end

   always_comb begin
      idx_sel_o = instr_i[6:5];
      amode = LBM_AM_PLAIN;
      offset = 8'h00;
      if (op_long_jump_op_idx) begin
         idx_sel_o = instr_i[1:0];
      end else if (op_zn) begin
         idx_sel_o = `LBM_IDX_Z;
         offset = instr_i[11:4];
      end else if (op_ma) begin
         offset = acc_i;
      end else if (op_mi) begin
         amode = lbm_amode_e'(instr_i[8:7]);
      end
   end

   lbm_addr_gen u_addr_gen (
      .mode_i(amode),
      .idx_i(idx_i),
      .offset_i(offset),
      .addr_o(ag_addr),
      .next_idx_o(ag_next_idx),
      .idx_upd_o(ag_upd)
   );

   // ==================================================
   // Next state
   always_comb begin
      next_state = state;
      next_pc = pc;
      next_target = target;
      next_is_call = is_call;
      next_take = take;
      next_dst = dst;
      next_reg_we = 1'b0;
      next_reg_waddr = reg_waddr;
      next_reg_wdata = reg_wdata;
      next_idx_we = 1'b0;
      next_idx_wsel = idx_wsel;
      next_idx_wdata = idx_wdata;
      next_dm_addr = dm_addr;
      next_dm_rd = dm_rd;
      next_dm_wr = dm_wr;
      next_dm_wdata = dm_wdata;
      next_stk_push = 1'b0;
      next_stk_data = stk_data;
      next_flags_we = 1'b0;
      next_flags_n = flags_n;
      next_flags_z = flags_z;
      case (state)
         LBM_IDLE: begin
            if (instr_valid_i) begin
               next_pc = pc + `LBM_PC_STEP;
               if (op_long_call_op || op_long_jump_op) begin
                  next_is_call = op_long_call_op;
                  next_take = 1'b1;
                  next_state = LBM_FETCH2;
               end else if (op_cjmp) begin
                  next_is_call = 1'b0;
                  next_take = (reg_rdata_i[instr_i[7:5]] == instr_i[8]);
                  next_state = LBM_FETCH2;
               end else if (op_long_jump_op_idx) begin
                  next_pc = idx_i;
               end else if (op_or) begin
                  next_reg_we = 1'b1;
                  next_reg_waddr = {1'b0, instr_i[3:0]};
                  next_reg_wdata = or_res;
                  next_flags_we = 1'b1;
                  next_flags_n = or_res[7];
                  next_flags_z = (or_res == 8'h00);
               end else if (op_rr) begin
                  next_reg_we = 1'b1;
                  next_reg_waddr = instr_i[4:0];
                  next_reg_wdata = reg_rdata_i;
               end else if (op_mi || op_ma || op_zn) begin
                  // Stores capture the source byte now, loads remember the destination
                  next_dm_addr = ag_addr;
                  next_dm_wdata = reg_rdata_i;
                  next_dst = reg_raddr_o;
                  next_dm_wr = op_zn ? instr_i[12] : instr_i[9];
                  next_dm_rd = !next_dm_wr;
                  next_idx_we = ag_upd;
                  next_idx_wsel = idx_sel_o;
                  next_idx_wdata = ag_next_idx;
                  next_state = LBM_MEM;
               end
            end
         end
         LBM_FETCH2: begin
            if (instr_valid_i) begin
               next_pc = pc + `LBM_PC_STEP;
               next_target = instr_i;
               if (is_call) begin
                  next_state = LBM_PUSH;
               end else begin
                  if (take) begin
                     next_pc = instr_i;
                  end
                  next_state = LBM_IDLE;
               end
            end
         end
         LBM_PUSH: begin
            next_stk_push = 1'b1;
            next_stk_data = {pc, global_irq_enable_i, flags_i, bank_i};
            next_state = LBM_LOAD;
         end
         LBM_LOAD: begin
            next_pc = target;
            next_state = LBM_IDLE;
         end
         LBM_MEM: begin
            if (dm_ack_i) begin
               next_dm_rd = 1'b0;
               next_dm_wr = 1'b0;
               if (dm_rd) begin
                  next_reg_we = 1'b1;
                  next_reg_waddr = dst;
                  next_reg_wdata = dm_rdata_i;
               end
               next_state = LBM_IDLE;
            end
         end
         default: begin
            next_state = LBM_IDLE;
         end
      endcase
      next_tx_push = next_reg_we && (next_reg_waddr == `LBM_TX_DATA_ADDR);
      next_tx_data = next_tx_push ? next_reg_wdata : tx_data;
   end

   // ==================================================
   // Registers
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state <= LBM_IDLE;
         pc <= `LBM_PC_RESET;
         target <= `LBM_PC_RESET;
         is_call <= 1'b0;
         take <= 1'b0;
         dst <= 5'h00;
         reg_we <= 1'b0;
         reg_waddr <= 5'h00;
         reg_wdata <= 8'h00;
         idx_we <= 1'b0;
         idx_wsel <= `LBM_IDX_W;
         idx_wdata <= 16'h0000;
         dm_addr <= 16'h0000;
         dm_rd <= 1'b0;
         dm_wr <= 1'b0;
         dm_wdata <= 8'h00;
         stk_push <= 1'b0;
         stk_data <= 25'h0000000;
         flags_we <= 1'b0;
         flags_n <= 1'b0;
         flags_z <= 1'b0;
         tx_push <= 1'b0;
         tx_data <= 8'h00;
      end else begin
         state <= next_state;
         pc <= next_pc;
         target <= next_target;
         is_call <= next_is_call;
         take <= next_take;
         dst <= next_dst;
         reg_we <= next_reg_we;
         reg_waddr <= next_reg_waddr;
         reg_wdata <= next_reg_wdata;
         idx_we <= next_idx_we;
         idx_wsel <= next_idx_wsel;
         idx_wdata <= next_idx_wdata;
         dm_addr <= next_dm_addr;
         dm_rd <= next_dm_rd;
         dm_wr <= next_dm_wr;
         dm_wdata <= next_dm_wdata;
         stk_push <= next_stk_push;
         stk_data <= next_stk_data;
         flags_we <= next_flags_we;
         flags_n <= next_flags_n;
         flags_z <= next_flags_z;
         tx_push <= next_tx_push;
         tx_data <= next_tx_data;
      end
   end

   // ==================================================
   // Outputs
   assign instr_ready_o = (state == LBM_IDLE) || (state == LBM_FETCH2);
   assign pc_o = pc;
   assign reg_we_o = reg_we;
   assign reg_waddr_o = reg_waddr;
   assign reg_wdata_o = reg_wdata;
   assign idx_we_o = idx_we;
   assign idx_wsel_o = idx_wsel;
   assign idx_wdata_o = idx_wdata;
   assign dm_addr_o = dm_addr;
   assign dm_rd_o = dm_rd;
   assign dm_wr_o = dm_wr;
   assign dm_wdata_o = dm_wdata;
   assign stk_push_o = stk_push;
   assign stk_data_o = stk_data;
   assign flags_we_o = flags_we;
   assign flags_n_o = flags_n;
   assign flags_z_o = flags_z;
   assign tx_push_o = tx_push;
   assign tx_data_o = tx_data;

endmodule

// ---- testbench/lbm_exec_props.sv ----
// Purpose: Port assertions for the execution block
// Assumes: One clock domain, synchronous reset
// Notes: Tracks two-word ops so that targets are not read as opcodes
`timescale 1ns/1ps
`include "lbm_map.svh"
module lbm_exec_props #(
   parameter int REG_AW = 5
) (
   // Control
   input wire logic clk_i, reset_i, instr_valid_i, instr_ready_o, reg_we_o, flags_we_o,
   input wire logic flags_n_o, flags_z_o, tx_push_o, stk_push_o, dm_rd_o, dm_ack_i,
   // Data
   input wire logic [15:0] instr_i, pc_o, idx_i, dm_addr_o,
   input wire logic [7:0] reg_rdata_i, reg_wdata_o, acc_i, dm_rdata_i, tx_data_o,
   input wire logic [REG_AW-1:0] reg_waddr_o
);
   logic take, first, pend, hit, next_pend, next_hit;
   logic [1:0] pop, next_pop;
   assign take = instr_valid_i && instr_ready_o;
   assign first = take && !pend;
   // ==========================
   // Second word tracking
   always_comb begin
      next_pend = pend;
      next_pop = pop;
      next_hit = hit;
      if (take && pend) begin
         next_pend = 1'b0;
      end else if (first && (instr_i[15:9] == 7'h67 || instr_i[15:9] == 7'h6a)) begin
         next_pend = 1'b1;
         next_pop = (instr_i[15:9] == 7'h6a) ? 2'h2 : {1'b0, instr_i[8]};
         next_hit = reg_rdata_i[instr_i[7:5]] == instr_i[8];
      end
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pend <= 1'b0;
         pop <= 2'h0;
         hit <= 1'b0;
      end else begin
         pend <= next_pend;
         pop <= next_pop;
         hit <= next_hit;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // ==========================
   // Properties
   jump_pc_a: assert property (take && pend && pop != 2'h0 |=>
      pc_o == ((pop == 2'h1 || hit) ? $past(instr_i) : $past(pc_o) + 16'h1)) else $error("jump target wrong");
   call_pc_a: assert property (take && pend && pop == 2'h0 |-> ##3 pc_o == $past(instr_i, 3))
      else $error("call target wrong");
   call_len_a: assert property (stk_push_o |-> !instr_ready_o && !$past(instr_ready_o) &&
      $past(instr_ready_o, 2) ##1 instr_ready_o) else $error("call length wrong");
   idx_jump_a: assert property (first && instr_i[15:2] == 14'h3340 |=> pc_o == $past(idx_i))
      else $error("indexed jump wrong");
   or_write_a: assert property (first && instr_i[15:12] == 4'h5 |=> reg_we_o && flags_we_o &&
      reg_waddr_o == $past({1'b0, instr_i[3:0]}) && reg_wdata_o == $past(reg_rdata_i | instr_i[11:4]) &&
      flags_z_o == (reg_wdata_o == 8'h0) && flags_n_o == reg_wdata_o[7]) else $error("or result wrong");
   flag_src_a: assert property (flags_we_o |-> $past(first && instr_i[15:12] == 4'h5))
      else $error("flags written by other op");
   move_rr_a: assert property (first && instr_i[15:10] == 6'h20 |=> reg_we_o &&
      reg_wdata_o == $past(reg_rdata_i) && reg_waddr_o == $past(instr_i[4:0])) else $error("move wrong");
   acc_addr_a: assert property (first && instr_i[15:10] == 6'h22 |=>
      dm_addr_o == $past(idx_i) + {8'h0, $past(acc_i)}) else $error("accumulator address wrong");
   imm_addr_a: assert property (first && instr_i[15:13] == 3'h7 |=>
      dm_addr_o == $past(idx_i) + {8'h0, $past(instr_i[11:4])}) else $error("immediate address wrong");
   load_data_a: assert property (dm_rd_o && dm_ack_i |=> reg_we_o && !dm_rd_o &&
      reg_wdata_o == $past(dm_rdata_i)) else $error("load data wrong");
   tx_push_a: assert property (reg_we_o && reg_waddr_o == `LBM_TX_DATA_ADDR |->
      tx_push_o && tx_data_o == reg_wdata_o) else $error("transmitter push missing");
endmodule
bind lbm_exec lbm_exec_props #(.REG_AW(REG_AW)) props_u (.*);

// ---- testbench/lbm_dmem_model.sv ----
// Purpose: Data memory that answers after a chosen number of cycles
// Assumes: Request held until the cycle after the acknowledge
// Notes: Read data is a toggling pattern outside the acknowledge cycle
`timescale 1ns/1ps
module lbm_dmem_model (
   input wire logic clk_i,
   input wire logic [15:0] dm_addr_i,
   input wire logic dm_rd_i,
   input wire logic dm_wr_i,
   input wire logic [1:0] lat_i,
   output logic [7:0] dm_rdata_o,
   output logic dm_ack_o
);
   logic [1:0] cnt = 2'h0;
   logic [7:0] junk = 8'h3c;
   assign dm_ack_o = (dm_rd_i || dm_wr_i) && cnt == lat_i;
   assign dm_rdata_o = dm_ack_o ? (dm_addr_i[7:0] ^ dm_addr_i[15:8] ^ 8'h5a) : junk;
   always @(posedge clk_i) begin
      junk <= ~junk;
      cnt <= (dm_rd_i || dm_wr_i) && !dm_ack_o ? cnt + 2'h1 : 2'h0;
   end
endmodule

// ---- testbench/test_long_branch_move_or_exec.sv ----
// Purpose: Self-checking bench for the execution block
// Assumes: Register file and index pointers are static bench tables
// Notes: Writes are noted in a queue and compared by a monitor
`timescale 1ns/1ps
`include "lbm_map.svh"
module test_long_branch_move_or_exec;
   import lbm_pkg::*;
   logic clk_i = 1'b0, reset_i = 1'b1, instr_valid_i = 1'b0, global_irq_enable_i = 1'b0;
   logic [15:0] instr_i = 16'h0, pc_o, dm_addr_o, idx_wdata_o, idx_i, t, pc0, a, w, ptr [4];
   logic [7:0] acc_i = 8'h0, reg_rdata_i, reg_wdata_o, dm_wdata_o, dm_rdata_i, tx_data_o, n8, regs [32];
   logic [4:0] reg_raddr_o, reg_waddr_o, src, rd, r5, rg;
   logic [3:0] flags_i = 4'h0, bank_i = 4'h0;
   logic [2:0] p;
   logic [1:0] idx_sel_o, idx_wsel_o, m, isel, lat = 2'h0;
   logic [24:0] stk_data_o;
   logic instr_ready_o, reg_we_o, idx_we_o, dm_rd_o, dm_wr_o, dm_ack_i, stk_push_o, s, ld;
   logic flags_we_o, flags_n_o, flags_z_o, tx_push_o;
   logic [25:0] exp_q [$];
   logic [31:0] seed = 32'h9343;
   int n_mismatch = 0, checks_done = 0, n;
   always #12.5 clk_i = ~clk_i;
   assign reg_rdata_i = regs[reg_raddr_o];
   assign idx_i = ptr[idx_sel_o];
   lbm_exec #(.REG_AW(5)) dut_u (.*);
   lbm_dmem_model dmem_u (.clk_i(clk_i), .dm_addr_i(dm_addr_o), .dm_rd_i(dm_rd_o), .dm_wr_i(dm_wr_o),
      .lat_i(lat), .dm_rdata_o(dm_rdata_i), .dm_ack_o(dm_ack_i));
   // ==========================
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input string nm, input logic [25:0] e, input logic [25:0] v);
      checks_done++;
      if (v !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, e, v);
      end
   endtask
   task automatic take_note(input string nm, input logic [25:0] v);
      logic [25:0] e;
      e = 26'h3ffffff;
      if (exp_q.size() > 0) e = exp_q.pop_front();
      chk(nm, e, v);
   endtask
   // Holds the word until an edge samples ready high
   task automatic put(input logic [15:0] wd);
      int k;
      k = 0;
      instr_i <= wd;
      instr_valid_i <= 1'b1;
      // Ready is read settled, so the rising edge that follows is the taking edge
      @(negedge clk_i);
      while (instr_ready_o !== 1'b1 && k < 40) begin
         k++;
         @(negedge clk_i);
      end
      if (k == 40) n_mismatch++;
      @(posedge clk_i);
   endtask
   task automatic idle(input int c);
      instr_valid_i <= 1'b0;
      repeat (c) @(posedge clk_i);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ==========================
   // Monitor
   // Falling edge: pulses launched on the rising edge are settled here
   always @(negedge clk_i) begin
      if (!reset_i) begin
         if (idx_we_o === 1'b1) take_note("index write", {2'h2, idx_wdata_o, 6'h0, idx_wsel_o});
         if (dm_wr_o === 1'b1 && dm_ack_i) take_note("memory write", {2'h1, dm_addr_o, dm_wdata_o});
         if (reg_we_o !== 1'b0) take_note("register write", {10'h0, flags_we_o, flags_we_o & flags_n_o,
            flags_we_o & flags_z_o, reg_waddr_o, reg_wdata_o});
         if (tx_push_o !== 1'b0) take_note("transmitter push", {18'h0, tx_data_o});
      end
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      n_mismatch++;
      give_verdict();
   end
   // ==========================
   // Tests
   initial begin
      for (int i = 0; i < 32; i++) regs[i] = 8'(rnd());
      for (int i = 0; i < 4; i++) ptr[i] = 16'(rnd());
      repeat (20) @(posedge clk_i);
      reset_i <= 1'b0;
      acc_i <= 8'(rnd());
      flags_i <= 4'(rnd());
      bank_i <= 4'(rnd());
      global_irq_enable_i <= 1'b1;
      for (int r = 0; r < 16; r++) begin
         n8 = 8'(rnd());
         w = {8'h00, regs[r] | n8};
         exp_q.push_back({10'h0, 1'b1, w[7], w[7:0] == 8'h00, 5'(r), w[7:0]});
         put({4'h5, n8, 4'(r)});
      end
      idle(2);
      $display("test or immediate finished");
      for (int i = 0; i < 8; i++) begin
         src = 5'(rnd());
         rd = (i == 0) ? `LBM_TX_DATA_ADDR : 5'(rnd());
         exp_q.push_back({13'h0, rd, regs[src]});
         if (rd == `LBM_TX_DATA_ADDR) exp_q.push_back({18'h0, regs[src]});
         put({6'h20, src, rd});
      end
      idle(2);
      $display("test register move finished");
      for (int i = 0; i < 8; i++) begin
         p = 3'(rnd());
         src = 5'(rnd());
         s = regs[src][p] ^ i[0];
         t = 16'(rnd());
         pc0 = pc_o;
         put(i == 7 ? 16'hcf00 : {7'h6a, s, p, src});
         put(t);
         idle(1);
         chk("jump target", 26'(!i[0] || i == 7 ? t : pc0 + 16'h2), 26'(pc_o));
      end
      for (int k = 0; k < 4; k++) begin
         put(16'hcd00 | 16'(k));
         idle(1);
         chk("indexed jump", 26'(ptr[k]), 26'(pc_o));
      end
      $display("test long jumps finished");
      pc0 = pc_o;
      t = 16'(rnd());
      put(16'hce00);
      put(t);
      instr_valid_i <= 1'b0;
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (stk_push_o !== 1'b1 && n < 10);
      chk("call duration", 26'h2, 26'(n));
      chk("stack word", {1'b0, pc0 + 16'h2, global_irq_enable_i, flags_i, bank_i}, {1'b0, stk_data_o});
      @(negedge clk_i);
      chk("call target", 26'(t), 26'(pc_o));
      @(posedge clk_i);
      $display("test long call finished");
      for (int i = 0; i < 24; i++) begin
         ld = i[0];
         m = 2'(i >> 1);
         isel = 2'(rnd());
         r5 = 5'(rnd());
         rg = r5;
         lat <= 2'(rnd());
         if (i < 8) begin
            a = ptr[isel] + {15'h0, m == 2'h1};
            w = {6'h21, !ld, m, isel, r5};
            if (m != 2'h0) exp_q.push_back({2'h2, m == 2'h2 ? ptr[isel] - 16'h1 : ptr[isel] + 16'h1,
               6'h0, isel});
         end else if (i < 16) begin
            a = ptr[isel] + {8'h0, acc_i};
            w = {6'h22, !ld, 2'h0, isel, r5};
         end else begin
            n8 = 8'(rnd());
            a = ptr[3] + {8'h0, n8};
            w = {3'h7, !ld, n8, r5[3:0]};
            rg = {1'b0, r5[3:0]};
         end
         exp_q.push_back(ld ? {13'h0, rg, a[7:0] ^ a[15:8] ^ 8'h5a} : {2'h1, a, regs[rg]});
         if (ld && rg == `LBM_TX_DATA_ADDR) exp_q.push_back({18'h0, a[7:0] ^ a[15:8] ^ 8'h5a});
         put(w);
      end
      idle(10);
      chk("pending results", 26'h0, 26'(exp_q.size()));
      $display("test data moves finished");
      give_verdict();
   end
endmodule
